// File: hw/spl_pkg.sv
// spl_pkg: constants, codes and carrier types of the strap configuration loader.
// assumes a 20 MHz system clock and 32-bit classic wishbone register access.
package spl_pkg;

	//////////////////////////////////////////////////////////////////////////////
	// strap pins and states
	localparam int          STRAP_PINS  = 4;
	localparam int          STATE_W     = 3;              // eight states, 0 to 7
	localparam int          PIN_INPUT   = 0;              // input_strap
	localparam int          PIN_AUX     = 1;              // aux_output_strap
	localparam int          PIN_XLAT_A  = 2;              // translation_strap_a
	localparam int          PIN_XLAT_B  = 3;              // translation_strap_b
	localparam int          PULLUP_BIT  = 2;              // state msb: 1 = pull-up to supply

	//////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int          CLK_HZ          = 20_000_000;
	localparam int          SETTLE_NS       = 1000;       // sense settling per pin
	localparam int          SETTLE_CYC      = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	//////////////////////////////////////////////////////////////////////////////
	// register map (byte addresses)
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [7:0]  ADDR_STRAPS = 8'h08;
	localparam logic [7:0]  ADDR_INPUT  = 8'h0C;
	localparam logic [7:0]  ADDR_AUX    = 8'h10;
	localparam logic [7:0]  ADDR_XLAT   = 8'h14;
	localparam int          CTRL_RESCAN = 0;              // write 1: start a new scan
	localparam int          ST_BUSY     = 0;
	localparam int          ST_VALID    = 1;
	localparam int          ST_HIT      = 2;

	//////////////////////////////////////////////////////////////////////////////
	// setting codes
	typedef enum logic [3:0] {
		FREQ_OFF, FREQ_25, FREQ_33P3, FREQ_50, FREQ_66P7, FREQ_100, FREQ_125,
		FREQ_133P3, FREQ_156P25, FREQ_200, FREQ_312P5, FREQ_400
	} spl_freq_t;

	typedef enum logic [2:0] {
		FMT_NONE, FMT_HSTL, FMT_LVDS, FMT_CMOS, FMT_HCSL, FMT_XTAL, FMT_DIFF
	} spl_fmt_t;

	typedef enum logic [2:0] {
		SRC_NONE, SRC_FRAC, SRC_INT_SRC, SRC_INT_OUT, SRC_INT_REF
	} spl_src_t;

	// input_strap result
	typedef struct packed {
		spl_fmt_t   primary_fmt;      // primary_ref_a / primary_ref_b receivers
		spl_fmt_t   third_fmt;        // third_reference_input receiver
		logic       int_from_third;   // integer_synth source: 1 = third input
		logic       frac_doubler;
		logic       int_doubler;
	} spl_input_cfg_t;

	// aux_output_strap result
	typedef struct packed {
		spl_freq_t  freq;
		spl_fmt_t   fmt;
		spl_src_t   src;
	} spl_aux_cfg_t;

	// translation result; group 0..3 = outputs 0-3, 4-5, 6-7, 8-9
	typedef struct packed {
		logic                 hit;    // index is a known translation
		spl_freq_t            ref_freq;
		spl_freq_t [3:0]      freq;
		spl_fmt_t  [3:0]      fmt;
		spl_src_t             src89;
	} spl_xlat_cfg_t;

	localparam spl_input_cfg_t INPUT_RST = '0;
	localparam spl_aux_cfg_t   AUX_RST   = '0;
	localparam spl_xlat_cfg_t  XLAT_RST  = '0;

endpackage : spl_pkg

// File: hw/spl_scanner.sv
// spl_scanner: walks the strap pins one after another and captures each sensed state.
// assumes the sensed states are synchronous to clk_i and settle within SETTLE cycles.
`timescale 1ns/1ps
module spl_scanner
	import spl_pkg::*;
#(
	parameter int PINS   = STRAP_PINS,
	parameter int SETTLE = SETTLE_CYC
) (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// control
	input  wire logic                   start_i,
	// sensed pin states
	input  wire logic [PINS*STATE_W-1:0] sense_i,
	// results
	output logic                         busy_o,
	output logic                         done_o,
	output logic [PINS*STATE_W-1:0]      states_o
);

	typedef enum logic [1:0] {SC_IDLE, SC_SETTLE, SC_CAPTURE} spl_scan_state_t;

	spl_scan_state_t              state_reg, state_next;
	logic [15:0]                  cnt_reg, cnt_next;
	logic [1:0]                   pin_reg, pin_next;
	logic [PINS*STATE_W-1:0]      cap_reg, cap_next;
	logic                         done_next;
	wire                          settled = (cnt_reg == 16'(SETTLE - 1));
	wire                          last_pin = (pin_reg == 2'(PINS - 1));

	//////////////////////////////////////////////////////////////////////////////
	// sequencer; a start restarts a scan already under way
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		pin_next   = pin_reg;
		cap_next   = cap_reg;
		done_next  = 1'b0;
		case (state_reg)
			SC_IDLE: begin
			end
			SC_SETTLE: begin
				cnt_next = cnt_reg + 16'h0001;
				if (settled) begin
					state_next = SC_CAPTURE;
				end
			end
			SC_CAPTURE: begin
				// one 3-bit state per pin
				cap_next[pin_reg*STATE_W +: STATE_W] = sense_i[pin_reg*STATE_W +: STATE_W]; // RQ2
				cnt_next = 16'h0000;
				if (last_pin) begin
					state_next = SC_IDLE;
					done_next  = 1'b1;
				end else begin
					pin_next   = pin_reg + 2'h1;
					state_next = SC_SETTLE;
				end
			end
			default: begin
				state_next = SC_IDLE;
			end
		endcase
		if (start_i) begin
			state_next = SC_SETTLE;
			cnt_next   = 16'h0000;
			pin_next   = 2'h0;
			done_next  = 1'b0;
		end
	end

	// state registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= SC_IDLE;
			cnt_reg   <= 16'h0000;
			pin_reg   <= 2'h0;
			cap_reg   <= '0;
			done_o    <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			pin_reg   <= pin_next;
			cap_reg   <= cap_next;
			done_o    <= done_next;
		end
	end

	assign busy_o   = (state_reg != SC_IDLE);
	assign states_o = cap_reg;

endmodule : spl_scanner

// File: hw/spl_loader.sv
// spl_loader: strap pin configuration loader with decoded power-on settings.
// assumes straps are already resolved to 3-bit sensed states, synchronous to clk_i,
// and a classic wishbone master on the register side.
// Operation
// RQ1 - scan all straps after power-on reset and after each external reset assertion.
// RQ2 - every strap scan yields one of eight states, a 3-bit value.
// RQ3 - states 0-3 mean pull-down, 4-7 pull-up; larger resistance, larger state.
// RQ4 - each block's power-on setting comes from its own strap's scanned state.
// RQ5 - strap 0 inputs, strap 1 auxiliary output, straps 2 and 3 translation.
// RQ6 - integer synth source: fractional active reference for 0-3, third input for 4-7.
// RQ7 - primary receivers crystal 0/4, cmos 1/2/5, differential 3/6/7; third crystal 4/6.
// RQ8 - fractional doubler off in states 2 and 3; integer doubler always off.
// RQ9 - auxiliary output frequency, format and source decoded from its strap.
// RQ10 - straps 2 and 3 form a 6-bit translation index; 0/0 disables outputs.
// RQ11 - each index sets reference, group frequencies, formats and outputs 8-9 source.
// RQ12 - decoded settings latch at scan end and hold until the next scan.
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module spl_loader
	import spl_pkg::*;
#(
	parameter int SETTLE = SETTLE_CYC
) (
	// clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	// external reset pin, active low
	input  wire logic                         ext_reset_n_i,
	// sensed strap states, pin 0 in the low bits
	input  wire logic [STRAP_PINS*STATE_W-1:0] strap_sense_i,
	// wishbone slave
	input  wire logic                         cyc_i,
	input  wire logic                         stb_i,
	input  wire logic                         we_i,
	input  wire logic [7:0]                   adr_i,
	input  wire logic [3:0]                   sel_i,
	input  wire logic [31:0]                  dat_i,
	output logic      [31:0]                  dat_o,
	output logic                              ack_o,
	// decoded settings and status
	output spl_input_cfg_t                    input_cfg_o,
	output spl_aux_cfg_t                      aux_cfg_o,
	output spl_xlat_cfg_t                     xlat_cfg_o,
	output logic      [STRAP_PINS*STATE_W-1:0] strap_states_o,
	output logic                              scan_busy_o,
	output logic                              cfg_valid_o
);

	//////////////////////////////////////////////////////////////////////////////
	// decode functions

	// input_strap: receivers, integer synth source, doublers
	function automatic spl_input_cfg_t dec_input(input logic [STATE_W-1:0] s);
		spl_input_cfg_t c;
		c = INPUT_RST;
		case (s)
			3'h0, 3'h4: c.primary_fmt = FMT_XTAL;                   // RQ7
			3'h1, 3'h2, 3'h5: c.primary_fmt = FMT_CMOS;             // RQ7
			default: c.primary_fmt = FMT_DIFF;                      // RQ7
		endcase
		c.third_fmt      = (s == 3'h4 || s == 3'h6) ? FMT_XTAL : FMT_CMOS; // RQ7
		c.int_from_third = s[PULLUP_BIT];                           // RQ6 RQ3
		c.frac_doubler   = !(s == 3'h2 || s == 3'h3);               // RQ8
		c.int_doubler    = 1'b0;                                    // RQ8
		return c;
	endfunction : dec_input

	// aux_output_strap: pull-ups give lvds, pull-downs cmos
	function automatic spl_aux_cfg_t dec_aux(input logic [STATE_W-1:0] s);
		spl_aux_cfg_t c;
		c.fmt = s[PULLUP_BIT] ? FMT_LVDS : FMT_CMOS;                // RQ9
		c.src = (s == 3'h0) ? SRC_INT_REF : SRC_INT_OUT;            // RQ9
		case (s)
			3'h0: c.freq = FREQ_25;
			3'h1: c.freq = FREQ_33P3;
			3'h2: c.freq = FREQ_50;
			3'h3: c.freq = FREQ_66P7;
			3'h4: c.freq = FREQ_100;
			3'h5: c.freq = FREQ_133P3;
			3'h6: c.freq = FREQ_200;
			default: c.freq = FREQ_400;
		endcase
		return c;
	endfunction : dec_aux

	// one translation row: four groups plus outputs 8-9 source
	function automatic spl_xlat_cfg_t row(
		input spl_freq_t f0, input spl_fmt_t m0,
		input spl_freq_t f1, input spl_fmt_t m1,
		input spl_freq_t f2, input spl_fmt_t m2,
		input spl_freq_t f3, input spl_fmt_t m3,
		input spl_src_t  src
	);
		spl_xlat_cfg_t c;
		c.hit      = 1'b1;
		c.ref_freq = FREQ_25;
		c.freq     = {f3, f2, f1, f0};
		c.fmt      = {m3, m2, m1, m0};
		c.src89    = src;
		return c;
	endfunction : row

	// translation index = {strap a, strap b}; unknown rows leave outputs off
	function automatic spl_xlat_cfg_t dec_xlat(input logic [2*STATE_W-1:0] idx);
		spl_xlat_cfg_t c;
		c = XLAT_RST;
		case (idx)
			6'h00: begin
				c.hit      = 1'b1;                                  // RQ10
				c.ref_freq = FREQ_25;
			end
			6'h01: c = row(FREQ_156P25, FMT_HSTL, FREQ_156P25, FMT_HSTL,
				FREQ_156P25, FMT_HSTL, FREQ_156P25, FMT_HSTL, SRC_FRAC);       // RQ10
			6'h02: c = row(FREQ_156P25, FMT_LVDS, FREQ_156P25, FMT_LVDS,
				FREQ_156P25, FMT_LVDS, FREQ_156P25, FMT_LVDS, SRC_FRAC);       // RQ10
			6'h03: c = row(FREQ_156P25, FMT_HSTL, FREQ_156P25, FMT_HSTL,
				FREQ_100, FMT_HSTL, FREQ_25, FMT_CMOS, SRC_INT_SRC);           // RQ11
			6'h04: c = row(FREQ_156P25, FMT_LVDS, FREQ_156P25, FMT_LVDS,
				FREQ_100, FMT_HSTL, FREQ_25, FMT_CMOS, SRC_INT_SRC);           // RQ11
			6'h05: c = row(FREQ_156P25, FMT_HSTL, FREQ_125, FMT_HSTL,
				FREQ_100, FMT_HSTL, FREQ_50, FMT_CMOS, SRC_INT_OUT);           // RQ11
			6'h06: c = row(FREQ_156P25, FMT_HSTL, FREQ_125, FMT_HSTL,
				FREQ_100, FMT_HSTL, FREQ_25, FMT_CMOS, SRC_INT_SRC);           // RQ11
			6'h07: c = row(FREQ_156P25, FMT_LVDS, FREQ_125, FMT_LVDS,
				FREQ_100, FMT_HSTL, FREQ_25, FMT_CMOS, SRC_INT_SRC);           // RQ11
			6'h08: c = row(FREQ_156P25, FMT_LVDS, FREQ_125, FMT_LVDS,
				FREQ_25, FMT_HSTL, FREQ_25, FMT_CMOS, SRC_INT_SRC);            // RQ11
			6'h09: c = row(FREQ_156P25, FMT_HSTL, FREQ_125, FMT_HSTL,
				FREQ_25, FMT_HSTL, FREQ_25, FMT_CMOS, SRC_INT_SRC);            // RQ11
			6'h0A: c = row(FREQ_156P25, FMT_HSTL, FREQ_100, FMT_HSTL,
				FREQ_50, FMT_HSTL, FREQ_125, FMT_HSTL, SRC_FRAC);              // RQ11
			6'h0B: c = row(FREQ_156P25, FMT_LVDS, FREQ_100, FMT_LVDS,
				FREQ_50, FMT_HSTL, FREQ_125, FMT_HSTL, SRC_FRAC);              // RQ11
			6'h0C: c = row(FREQ_156P25, FMT_LVDS, FREQ_100, FMT_LVDS,
				FREQ_100, FMT_LVDS, FREQ_25, FMT_CMOS, SRC_INT_SRC);           // RQ11
			6'h0D: c = row(FREQ_156P25, FMT_HSTL, FREQ_100, FMT_HSTL,
				FREQ_25, FMT_HSTL, FREQ_25, FMT_CMOS, SRC_INT_SRC);            // RQ11
			default: c = XLAT_RST;
		endcase
		return c;
	endfunction : dec_xlat

	//////////////////////////////////////////////////////////////////////////////
	// scan triggers

	logic                              boot_reg;
	logic                              rescan_reg;
	logic [STRAP_PINS*STATE_W-1:0]     states;
	logic                              scan_busy;
	logic                              scan_done;

	// restart held while the pin is low, so the scan runs after its release
	wire ext_asserted = !ext_reset_n_i;
	wire scan_start   = boot_reg || ext_asserted || rescan_reg;           // RQ1

	// first cycle after power-on reset release requests a scan
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			boot_reg    <= 1'b1;
		end else begin
			boot_reg    <= 1'b0;                                            // RQ1
		end
	end

	spl_scanner #(
		.PINS   (STRAP_PINS),
		.SETTLE (SETTLE)
	) u_scanner (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.start_i  (scan_start),
		.sense_i  (strap_sense_i),
		.busy_o   (scan_busy),
		.done_o   (scan_done),
		.states_o (states)
	);

	//////////////////////////////////////////////////////////////////////////////
	// decode from the captured states, one strap per block, two for translation
	wire [STATE_W-1:0]  st_input = states[PIN_INPUT*STATE_W +: STATE_W];     // RQ5 RQ4
	wire [STATE_W-1:0]  st_aux   = states[PIN_AUX*STATE_W +: STATE_W];       // RQ5 RQ4
	wire [STATE_W-1:0]  st_xa    = states[PIN_XLAT_A*STATE_W +: STATE_W];    // RQ5
	wire [STATE_W-1:0]  st_xb    = states[PIN_XLAT_B*STATE_W +: STATE_W];    // RQ5
	wire spl_input_cfg_t input_dec = dec_input(st_input);
	wire spl_aux_cfg_t   aux_dec   = dec_aux(st_aux);
	wire spl_xlat_cfg_t  xlat_dec  = dec_xlat({st_xa, st_xb});               // RQ10

	// latch on scan completion only; a scan in progress keeps the old values
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			input_cfg_o    <= INPUT_RST;
			aux_cfg_o      <= AUX_RST;
			xlat_cfg_o     <= XLAT_RST;
			strap_states_o <= '0;
		end else if (scan_done) begin
			input_cfg_o    <= input_dec;                                      // RQ12
			aux_cfg_o      <= aux_dec;                                        // RQ12
			xlat_cfg_o     <= xlat_dec;                                       // RQ12
			strap_states_o <= states;                                         // RQ12
		end
	end

	// status flags; valid drops as soon as a new scan starts
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scan_busy_o <= 1'b0;
			cfg_valid_o <= 1'b0;
		end else begin
			scan_busy_o <= scan_busy || scan_start;
			cfg_valid_o <= scan_done || (cfg_valid_o && !scan_start);
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// wishbone slave: one wait state, ack for one cycle, unmapped reads zero
	wire        req       = cyc_i && stb_i && !ack_o;
	wire        wr_ctrl   = req && we_i && sel_i[0] && (adr_i == ADDR_CTRL);
	wire [31:0] status_w  = {29'h0, xlat_cfg_o.hit, cfg_valid_o, scan_busy_o};
	logic [31:0] rd_mux;

	// read data select
	always_comb begin
		case (adr_i)
			ADDR_STATUS: rd_mux = status_w;
			ADDR_STRAPS: rd_mux = 32'(strap_states_o);
			ADDR_INPUT:  rd_mux = 32'(input_cfg_o);
			ADDR_AUX:    rd_mux = 32'(aux_cfg_o);
			ADDR_XLAT:   rd_mux = 32'(xlat_cfg_o);
			default:     rd_mux = 32'h0000_0000;
		endcase
	end

	// rescan request is a self-clearing pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o      <= 1'b0;
			dat_o      <= 32'h0000_0000;
			rescan_reg <= 1'b0;
		end else begin
			ack_o      <= req;
			dat_o      <= (req && !we_i) ? rd_mux : 32'h0000_0000;
			rescan_reg <= wr_ctrl && dat_i[CTRL_RESCAN];
		end
	end

endmodule : spl_loader

// File: testbench/spl_strap_board.sv
// spl_strap_board: board resistors on the four strap pins, already resolved to states.
// assumes the bench picks the terminus and the resistor rank of every pin.
`timescale 1ns/1ps
module spl_strap_board (
	// terminus (1 = supply) and rank per pin
	input  wire logic        pull_up_i,
	input  wire logic [7:0]  rank_i,
	input  wire logic [3:0]  pu_i,
	// sensed states, pin 0 in the low bits
	output logic      [11:0] sense_o
);
	// pull-up in the msb, larger resistor gives a larger state
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			sense_o[3*k +: 3] = {pu_i[k] & pull_up_i, rank_i[2*k +: 2]};
		end
	end
endmodule : spl_strap_board

// File: testbench/spl_loader_checker.sv
// spl_loader_checker: port-level assertions on the strap loader.
// assumes one clock domain and the synchronous reset of the top module.
`timescale 1ns/1ps
module spl_loader_checker
	import spl_pkg::*;
#(
	parameter int SETTLE = SETTLE_CYC
) (
	// clock, reset, pins
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire logic                   ext_reset_n_i,
	// settings and status
	input wire spl_input_cfg_t         input_cfg_o,
	input wire spl_aux_cfg_t           aux_cfg_o,
	input wire spl_xlat_cfg_t          xlat_cfg_o,
	input wire logic [STRAP_PINS*STATE_W-1:0] strap_states_o,
	input wire logic                   scan_busy_o,
	input wire logic                   cfg_valid_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	localparam int SCAN_MAX = 200;   // covers the full settle count too
	wire logic [2:0] in_s = strap_states_o[2:0];

	sequence scan_start;
		$rose(scan_busy_o);
	endsequence
	sequence scan_done;
		##[1:SCAN_MAX] $rose(cfg_valid_o);
	endsequence

	boot_scan_a: assert property ($fell(rst_i) |=> scan_busy_o)
		else $error("no scan after reset");
	ext_drop_a: assert property (!ext_reset_n_i |=> !cfg_valid_o)
		else $error("settings valid during pin reset");
	scan_end_a: assert property (scan_start |-> scan_done)
		else $error("scan never completed");
	hold_cfg_a: assert property (cfg_valid_o && $past(cfg_valid_o) |->
		$stable(input_cfg_o) && $stable(aux_cfg_o) && $stable(xlat_cfg_o))
		else $error("settings moved while held");
	src_sel_a: assert property (cfg_valid_o |-> input_cfg_o.int_from_third == in_s[2])
		else $error("integer synth source wrong");
	dbl_off_a: assert property (cfg_valid_o |-> !input_cfg_o.int_doubler &&
		input_cfg_o.frac_doubler == (in_s[2:1] != 2'h1))
		else $error("doubler state wrong");
	third_fmt_a: assert property (cfg_valid_o |-> input_cfg_o.third_fmt ==
		((in_s == 3'h4 || in_s == 3'h6) ? FMT_XTAL : FMT_CMOS))
		else $error("third receiver format wrong");
	aux_fmt_a: assert property (cfg_valid_o |->
		aux_cfg_o.fmt == (strap_states_o[5] ? FMT_LVDS : FMT_CMOS))
		else $error("aux format wrong");
	xlat_off_a: assert property (cfg_valid_o && strap_states_o[11:6] == 6'h00 |->
		xlat_cfg_o.hit && xlat_cfg_o.freq == '0)
		else $error("outputs not disabled");
endmodule : spl_loader_checker

bind spl_loader spl_loader_checker #(.SETTLE(SETTLE)) chk_u (
	.clk_i(clk_i), .rst_i(rst_i), .ext_reset_n_i(ext_reset_n_i),
	.input_cfg_o(input_cfg_o), .aux_cfg_o(aux_cfg_o), .xlat_cfg_o(xlat_cfg_o),
	.strap_states_o(strap_states_o), .scan_busy_o(scan_busy_o), .cfg_valid_o(cfg_valid_o)
);

// File: testbench/spl_loader_tb.sv
// spl_loader_tb: scenario tasks for the strap loader, short settle count.
// assumes the board model on the strap inputs and a wishbone master in the bench.
`timescale 1ns/1ps
module spl_loader_tb;
	import spl_pkg::*;
	logic        clk_i, rst_i, ext_reset_n_i, cyc_i, stb_i, we_i;
	logic [7:0]  adr_i, rank;
	logic [3:0]  sel_i, pu;
	logic [31:0] dat_i, dat_o, q;
	logic        ack_o, scan_busy_o, cfg_valid_o;
	logic [11:0] sense, strap_states_o;
	spl_input_cfg_t input_cfg_o;
	spl_aux_cfg_t   aux_cfg_o;
	spl_xlat_cfg_t  xlat_cfg_o;
	int n_fail = 0;
	int checks_done = 0;

	spl_strap_board brd_u (.pull_up_i(1'h1), .rank_i(rank), .pu_i(pu), .sense_o(sense));
	spl_loader #(.SETTLE(2)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.ext_reset_n_i(ext_reset_n_i), .strap_sense_i(sense), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .input_cfg_o(input_cfg_o), .aux_cfg_o(aux_cfg_o),
		.xlat_cfg_o(xlat_cfg_o), .strap_states_o(strap_states_o),
		.scan_busy_o(scan_busy_o), .cfg_valid_o(cfg_valid_o));

	//////////////////////////////////////////////////////////////////////////////
	// shared tasks and expectation tables
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic straps(input logic [11:0] s); // s = {b, a, aux, input}
		@(posedge clk_i);
		pu   <= {s[11], s[8], s[5], s[2]};
		rank <= {s[10:9], s[7:6], s[4:3], s[1:0]};
	endtask : straps

	// holds the request until ack is seen high at an edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'hF};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'h1 && n < 20);
		q = dat_o;
		chk(ack_o, 1'h1);
		{cyc_i, stb_i} <= 2'h0;
	endtask : wb

	// old valid first has to drop, so a stale level is never taken
	task automatic wait_valid;
		int n;
		n = 0;
		while (cfg_valid_o !== 1'h0 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		while (cfg_valid_o !== 1'h1 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		chk(cfg_valid_o, 1'h1);
	endtask : wait_valid

	function automatic spl_input_cfg_t exp_in(input logic [2:0] s);
		spl_input_cfg_t e;
		e.primary_fmt    = (s == 3'h0 || s == 3'h4) ? FMT_XTAL :
			(s == 3'h1 || s == 3'h2 || s == 3'h5) ? FMT_CMOS : FMT_DIFF;
		e.third_fmt      = (s == 3'h4 || s == 3'h6) ? FMT_XTAL : FMT_CMOS;
		e.int_from_third = s[2];
		e.frac_doubler   = !(s == 3'h2 || s == 3'h3);
		e.int_doubler    = 1'h0;
		return e;
	endfunction : exp_in

	function automatic spl_aux_cfg_t exp_aux(input logic [2:0] s);
		spl_freq_t ft [8] = '{FREQ_25, FREQ_33P3, FREQ_50, FREQ_66P7, FREQ_100,
			FREQ_133P3, FREQ_200, FREQ_400};
		return spl_aux_cfg_t'{ft[s], s[2] ? FMT_LVDS : FMT_CMOS,
			(s == 3'h0) ? SRC_INT_REF : SRC_INT_OUT};
	endfunction : exp_aux

	// rows with translation_strap_a at 0
	function automatic spl_xlat_cfg_t exp_x(input logic [2:0] b);
		spl_xlat_cfg_t e;
		logic o;
		o = (b == 3'h0);
		e.hit = 1'h1;
		e.ref_freq = FREQ_25;
		e.freq[0] = o ? FREQ_OFF : FREQ_156P25;
		e.freq[1] = o ? FREQ_OFF : (b < 3'h5) ? FREQ_156P25 : FREQ_125;
		e.freq[2] = o ? FREQ_OFF : (b < 3'h3) ? FREQ_156P25 : FREQ_100;
		e.freq[3] = o ? FREQ_OFF : (b < 3'h3) ? FREQ_156P25 : (b == 3'h5) ? FREQ_50 : FREQ_25;
		e.fmt[0] = o ? FMT_NONE : (b == 3'h2 || b == 3'h4 || b == 3'h7) ? FMT_LVDS : FMT_HSTL;
		e.fmt[1] = e.fmt[0];
		e.fmt[2] = o ? FMT_NONE : (b == 3'h2) ? FMT_LVDS : FMT_HSTL;
		e.fmt[3] = o ? FMT_NONE : (b < 3'h3) ? e.fmt[2] : FMT_CMOS;
		e.src89 = o ? SRC_NONE : (b < 3'h3) ? SRC_FRAC : (b == 3'h5) ? SRC_INT_OUT : SRC_INT_SRC;
		return e;
	endfunction : exp_x

	//////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_boot; // pair 1/2 tells index halves apart
		spl_xlat_cfg_t e;
		e = '{1'h1, FREQ_25, '{FREQ_125, FREQ_50, FREQ_100, FREQ_156P25},
			'{4{FMT_HSTL}}, SRC_FRAC};
		wait_valid;
		chk(strap_states_o, 12'h46E);
		chk(input_cfg_o, exp_in(3'h6));
		chk(aux_cfg_o, exp_aux(3'h5));
		chk(xlat_cfg_o, e);
	endtask : t_boot

	task automatic t_tables; // every state on input and strap b, its complement on aux, strap a at 0
		logic [2:0] s;
		for (int i = 0; i < 8; i++) begin
			s = 3'(i);
			straps({s, 3'h0, ~s, s});
			wb(1'h1, ADDR_CTRL, 32'h1);
			wait_valid;
			chk(input_cfg_o, exp_in(s));
			chk(aux_cfg_o, exp_aux(~s));
			chk(xlat_cfg_o, exp_x(s));
		end
	endtask : t_tables

	task automatic t_hold_ext; // new straps unseen until the pin reset
		straps(12'h603);
		repeat (8) @(posedge clk_i);
		chk(input_cfg_o, exp_in(3'h7));
		ext_reset_n_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		ext_reset_n_i <= 1'h1;
		chk(cfg_valid_o, 1'h0);
		chk(xlat_cfg_o, exp_x(3'h7));
		wait_valid;
		chk(input_cfg_o, exp_in(3'h3));
		chk(xlat_cfg_o, exp_x(3'h3));
	endtask : t_hold_ext

	task automatic t_bus; // status, a stray write, an unmapped read
		wb(1'h1, ADDR_STATUS, 32'hFFFFFFFF);
		wb(1'h0, ADDR_STATUS, 32'h0);
		chk(q, 32'h6);
		wb(1'h0, 8'h20, 32'h0);
		chk(q, 32'h0);
		wb(1'h0, ADDR_STRAPS, 32'h0);
		chk(q, 32'h603);
		wb(1'h0, ADDR_INPUT, 32'h0);
		chk(q, 32'(exp_in(3'h3)));
		wb(1'h0, ADDR_AUX, 32'h0);
		chk(q, 32'(exp_aux(3'h0)));
		wb(1'h0, ADDR_XLAT, 32'h0);
		chk(q, 32'(exp_x(3'h3)));
	endtask : t_bus

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	//////////////////////////////////////////////////////////////////////////////
	// clock, sequence, watchdog
	initial begin
		clk_i = 1'h0;
		forever #25 clk_i = ~clk_i;
	end

	initial begin
		{rst_i, ext_reset_n_i, cyc_i, stb_i, we_i} = 5'h18;
		{adr_i, sel_i, dat_i} = '0;
		{pu, rank} = {4'h3, 8'h96}; // straps 2, 1, 5, 6
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		t_boot;
		t_tables;
		t_hold_ext;
		t_bus;
		complete_run;
	end

	initial begin // ten scans need about 200 cycles
		repeat (5000) @(posedge clk_i);
		n_fail++;
		complete_run;
	end
endmodule : spl_loader_tb
